/* File: verilog/pio_port.sv */
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Parallel port with active and passive strobes, behind an AXI4-Lite slave
module pio_port (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [15:0] parallel_data_bus_in,
	output logic [15:0] parallel_data_bus_out,
	output logic [15:0] parallel_data_bus_oe,
	input wire logic input_data_strobe_n_in,
	output logic input_data_strobe_n_out,
	output logic input_data_strobe_n_oe,
	input wire logic output_data_strobe_n_in,
	output logic output_data_strobe_n_out,
	output logic output_data_strobe_n_oe,
	output logic port_select,
	output logic irq_input_req,
	output logic irq_output_req,
	input wire logic int_accept,
	input wire logic int_done,
	output logic interrupt_acknowledge
);
	////////////////////////////////////////////////////////////////
	// Helpers
	// Merge the two low byte lanes of a write into a 16-bit register
	function automatic logic [15:0] merge_lanes(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] strb);
		logic [15:0] res;
		res = old;
		if (strb[0]) begin
			res[7:0] = wd[7:0];
		end
		if (strb[1]) begin
			res[15:8] = wd[15:8];
		end
		return res;
	endfunction

	// Data windows start a port transaction; bit 3 picks the logical port
	function automatic logic is_data(input logic [7:0] a);
		return (a == pio_pkg::ADDR_DATA0) || (a == pio_pkg::ADDR_DATA1);
	endfunction

	////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [pio_pkg::PIN_W-1:0] pin_sync; // {ods, ids, bus}
	logic ids_d_reg, ids_d_next; // Previous synced input strobe
	logic ods_d_reg, ods_d_next; // Previous synced output strobe
	logic ids_s, ods_s;
	logic [15:0] bus_s;

	pio_sync #(.W(pio_pkg::PIN_W), .RST_VAL(pio_pkg::PIN_IDLE)) u_sync (
		.core_clk(core_clk),
		.rst(rst),
		.async_in({output_data_strobe_n_in, input_data_strobe_n_in, parallel_data_bus_in}),
		.sync_out(pin_sync)
	);
	assign bus_s = pin_sync[15:0];
	assign ids_s = pin_sync[16];
	assign ods_s = pin_sync[17];

	////////////////////////////////////////////////////////////////
	// State
	logic [15:0] ctrl_reg, ctrl_next; // Width, strobe directions, S/C, masks
	logic [15:0] out_reg, out_next; // Parallel output register
	logic [15:0] in_reg, in_next; // Parallel input register
	logic [15:0] shadow_reg, shadow_next; // Input register saved at interrupt entry
	logic shadow_vld_reg, shadow_vld_next;
	logic viol_reg, viol_next; // Sticky: transaction refused for spacing
	logic aw_held_reg, aw_held_next;
	logic [7:0] aw_addr_reg, aw_addr_next;
	logic w_held_reg, w_held_next;
	logic [31:0] w_data_reg, w_data_next;
	logic [3:0] w_strb_reg, w_strb_next;
	logic awready_next, wready_next, bvalid_next, arready_next, rvalid_next;
	logic [1:0] bresp_next, rresp_next;
	logic [31:0] rdata_next;
	pio_pkg::pio_eng_t eng_reg, eng_next; // Strobe engine state
	logic [3:0] cnt_reg, cnt_next; // Cycles left in the current engine phase
	logic eng_wr_reg, eng_wr_next; // Transaction kind: high write, low read
	logic sel_reg, sel_next; // Logical port of the latest active transaction
	logic ids_out_reg, ids_out_next; // Driven input strobe level
	logic ods_out_reg, ods_out_next; // Driven output strobe level
	logic ids_oe_reg, ids_oe_next; // Input strobe driven by this port
	logic ods_oe_reg, ods_oe_next; // Output strobe driven by this port
	logic [15:0] pdb_out_reg, pdb_out_next; // Bus value driven
	logic [15:0] pdb_oe_reg, pdb_oe_next; // Bus lanes driven
	logic irq_in_reg, irq_in_next; // Passive write interrupt pending
	logic irq_out_reg, irq_out_next; // Passive read interrupt pending
	logic interrupt_acknowledge_reg, interrupt_acknowledge_next; // Acknowledge output level
	logic ids_rise, ods_rise; // Host strobe trailing edges, passive only
	logic wr_fire, rd_take; // Write performed, read address taken
	logic wr_busy, rd_busy; // Request refused for spacing
	logic wr_known, rd_known; // Address decodes to a writable register, or for reads any register
	logic act_wr_go, act_rd_go; // Active transaction launched
	logic accept; // Interrupt taken while a request is pending
	logic capture; // Active read samples the bus
	logic [3:0] width_cyc; // Strobe length in clocks
	logic [31:0] rd_word; // Decoded read value

	////////////////////////////////////////////////////////////////
	// Strobe length and passive edge detection
	// Edge history resets high, the idle pin level, so reset gives no false edge
	always_comb begin
		width_cyc = 4'((4'(ctrl_reg[pio_pkg::CTRL_WIDTH_LSB +: 2]) + 4'h1)
			* pio_pkg::T_UNIT_CYCLES);
		ids_d_next = ids_s;
		ods_d_next = ods_s;
		ids_rise = ids_s && !ids_d_reg && !ctrl_reg[pio_pkg::CTRL_IN_ACT];
		ods_rise = ods_s && !ods_d_reg && !ctrl_reg[pio_pkg::CTRL_OUT_ACT];
		accept = int_accept && (irq_in_reg || irq_out_reg);
	end

	////////////////////////////////////////////////////////////////
	// Write channels: address and data held until both are in
	always_comb begin
		aw_held_next = aw_held_reg;
		aw_addr_next = aw_addr_reg;
		w_held_next = w_held_reg;
		w_data_next = w_data_reg;
		w_strb_next = w_strb_reg;
		awready_next = 1'b0;
		wready_next = 1'b0;
		bvalid_next = s_axi_bvalid;
		bresp_next = s_axi_bresp;
		wr_fire = 1'b0;
		// Data windows refuse a new active write while the engine runs
		wr_busy = is_data(aw_addr_reg) && ctrl_reg[pio_pkg::CTRL_OUT_ACT]
			&& (eng_reg != pio_pkg::ENG_IDLE);
		wr_known = (aw_addr_reg == pio_pkg::ADDR_CTRL) || is_data(aw_addr_reg);
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_next = 1'b1;
			aw_addr_next = s_axi_awaddr;
		end else if (s_axi_awvalid && !aw_held_reg && !s_axi_bvalid) begin
			awready_next = 1'b1; // One-cycle ready pulse
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_next = 1'b1;
			w_data_next = s_axi_wdata;
			w_strb_next = s_axi_wstrb;
		end else if (s_axi_wvalid && !w_held_reg && !s_axi_bvalid) begin
			wready_next = 1'b1;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		// Both halves in: perform the write and answer
		if (aw_held_reg && w_held_reg && !s_axi_bvalid) begin
			wr_fire = 1'b1;
			aw_held_next = 1'b0;
			w_held_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = (wr_known && !wr_busy) ? pio_pkg::RESP_OKAY : pio_pkg::RESP_SLVERR;
		end
		act_wr_go = wr_fire && wr_known && !wr_busy && is_data(aw_addr_reg)
			&& ctrl_reg[pio_pkg::CTRL_OUT_ACT];
	end

	////////////////////////////////////////////////////////////////
	// Read channel: answer one cycle after the address is taken
	always_comb begin
		arready_next = 1'b0;
		rvalid_next = s_axi_rvalid;
		rdata_next = s_axi_rdata;
		rresp_next = s_axi_rresp;
		rd_take = s_axi_arvalid && s_axi_arready;
		rd_known = 1'b1;
		rd_busy = 1'b0;
		rd_word = 32'h0000_0000;
		if (s_axi_araddr == pio_pkg::ADDR_CTRL) begin
			rd_word = {16'h0000, ctrl_reg};
		end else if (is_data(s_axi_araddr)) begin
			// A read launches an active input, so it also keeps the spacing
			rd_busy = ctrl_reg[pio_pkg::CTRL_IN_ACT]
				&& ((eng_reg != pio_pkg::ENG_IDLE) || act_wr_go);
			rd_word = rd_busy ? 32'h0000_0000 : {16'h0000, in_reg};
		end else if (s_axi_araddr == pio_pkg::ADDR_STATUS) begin
			rd_word[pio_pkg::ST_BUSY] = (eng_reg != pio_pkg::ENG_IDLE);
			rd_word[pio_pkg::ST_IRQ_IN] = irq_in_reg;
			rd_word[pio_pkg::ST_IRQ_OUT] = irq_out_reg;
			rd_word[pio_pkg::ST_INTERRUPT_ACKNOWLEDGE] = interrupt_acknowledge_reg;
			rd_word[pio_pkg::ST_VIOL] = viol_reg;
			rd_word[pio_pkg::ST_SHADOW] = shadow_vld_reg;
		end else if (s_axi_araddr == pio_pkg::ADDR_OUTREG) begin
			rd_word = {16'h0000, out_reg};
		end else begin
			rd_known = 1'b0;
		end
		if (s_axi_rvalid && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
		if (rd_take) begin
			rvalid_next = 1'b1;
			rdata_next = rd_word;
			rresp_next = (rd_known && !rd_busy) ? pio_pkg::RESP_OKAY : pio_pkg::RESP_SLVERR;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			arready_next = 1'b1;
		end
		act_rd_go = rd_take && is_data(s_axi_araddr) && !rd_busy
			&& ctrl_reg[pio_pkg::CTRL_IN_ACT];
	end

	////////////////////////////////////////////////////////////////
	// Control, data and shadow registers
	always_comb begin
		ctrl_next = ctrl_reg;
		out_next = out_reg;
		in_next = in_reg;
		shadow_next = shadow_reg;
		shadow_vld_next = shadow_vld_reg;
		viol_next = viol_reg;
		if (wr_fire && (aw_addr_reg == pio_pkg::ADDR_CTRL)) begin
			ctrl_next = (merge_lanes(ctrl_reg, w_data_reg, w_strb_reg) & pio_pkg::CTRL_WMASK)
				| (ctrl_reg & ~pio_pkg::CTRL_WMASK);
			viol_next = 1'b0; // A control write clears the refusal flag
		end
		if (wr_fire && is_data(aw_addr_reg) && !wr_busy) begin
			out_next = merge_lanes(out_reg, w_data_reg, w_strb_reg);
		end
		// Set wins over a clear in the same cycle
		if ((wr_fire && wr_busy) || (rd_take && rd_busy)) begin
			viol_next = 1'b1;
		end
		// Passive write and active read both sample on the strobe rise
		if (ids_rise || capture) begin
			in_next = bus_s;
		end
		// Shadow only while the input strobe is active
		if (accept && ctrl_reg[pio_pkg::CTRL_IN_ACT]) begin
			shadow_next = in_reg;
			shadow_vld_next = 1'b1;
		end else if (!ctrl_reg[pio_pkg::CTRL_IN_ACT]) begin
			shadow_vld_next = 1'b0; // Switch to passive drops the shadow
		end
		if (int_done && shadow_vld_reg && ctrl_reg[pio_pkg::CTRL_IN_ACT]) begin
			in_next = shadow_reg;
			shadow_vld_next = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Interrupt requests and acknowledge
	always_comb begin
		irq_in_next = irq_in_reg;
		irq_out_next = irq_out_reg;
		interrupt_acknowledge_next = interrupt_acknowledge_reg;
		if (accept) begin
			irq_in_next = 1'b0;
			irq_out_next = 1'b0;
			interrupt_acknowledge_next = 1'b1;
		end
		if (int_done) begin
			interrupt_acknowledge_next = 1'b0;
		end
		// A new edge in the accept cycle still wins
		if (ids_rise && ctrl_reg[pio_pkg::CTRL_MASK_IN]) begin
			irq_in_next = 1'b1;
		end
		if (ods_rise && ctrl_reg[pio_pkg::CTRL_MASK_OUT]) begin
			irq_out_next = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// Strobe engine: strobe phase, then hold or sampling phase
	// Minimum width gives a one-clock strobe, so port accesses run back to back
	always_comb begin
		eng_next = eng_reg;
		cnt_next = cnt_reg;
		eng_wr_next = eng_wr_reg;
		sel_next = sel_reg;
		capture = 1'b0;
		case (eng_reg)
			pio_pkg::ENG_IDLE: begin
				if (act_wr_go) begin
					eng_next = pio_pkg::ENG_STROBE;
					cnt_next = width_cyc;
					eng_wr_next = 1'b1;
					sel_next = (aw_addr_reg == pio_pkg::ADDR_DATA1);
				end else if (act_rd_go) begin
					eng_next = pio_pkg::ENG_STROBE;
					cnt_next = width_cyc;
					eng_wr_next = 1'b0;
					sel_next = (s_axi_araddr == pio_pkg::ADDR_DATA1);
				end
			end
			pio_pkg::ENG_STROBE: begin
				if (cnt_reg <= 4'h1) begin
					eng_next = pio_pkg::ENG_GAP;
					// Writes hold data one clock; reads wait out the synchroniser
					cnt_next = eng_wr_reg ? 4'h1 : 4'(pio_pkg::SYNC_STAGES);
				end else begin
					cnt_next = cnt_reg - 4'h1;
				end
			end
			pio_pkg::ENG_GAP: begin
				if (cnt_reg <= 4'h1) begin
					eng_next = pio_pkg::ENG_IDLE;
					cnt_next = 4'h0;
					capture = !eng_wr_reg;
				end else begin
					cnt_next = cnt_reg - 4'h1;
				end
			end
			default: begin
				eng_next = pio_pkg::ENG_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Pin drive: strobes from the next engine state, bus lanes by mode
	always_comb begin
		ids_oe_next = ctrl_reg[pio_pkg::CTRL_IN_ACT];
		ods_oe_next = ctrl_reg[pio_pkg::CTRL_OUT_ACT];
		ids_out_next = 1'b1;
		ods_out_next = 1'b1;
		pdb_out_next = pdb_out_reg;
		pdb_oe_next = 16'h0000;
		if (eng_next == pio_pkg::ENG_STROBE) begin
			if (eng_wr_next) begin
				ods_out_next = 1'b0;
			end else begin
				ids_out_next = 1'b0;
			end
		end
		if ((eng_next != pio_pkg::ENG_IDLE) && eng_wr_next) begin
			pdb_out_next = out_next;
			pdb_oe_next = 16'hffff;
		end else if (!ctrl_reg[pio_pkg::CTRL_OUT_ACT] && !ods_s) begin
			pdb_out_next = out_reg;
			pdb_oe_next = 16'hffff;
		end
		// Status/control mode keeps the upper byte input only
		if (ctrl_reg[pio_pkg::CTRL_SC]) begin
			pdb_oe_next[15:8] = 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////
	// Bus interface registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_held_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= pio_pkg::RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= pio_pkg::RESP_OKAY;
		end else begin
			aw_held_reg <= aw_held_next;
			aw_addr_reg <= aw_addr_next;
			w_held_reg <= w_held_next;
			w_data_reg <= w_data_next;
			w_strb_reg <= w_strb_next;
			s_axi_awready <= awready_next;
			s_axi_wready <= wready_next;
			s_axi_bvalid <= bvalid_next;
			s_axi_bresp <= bresp_next;
			s_axi_arready <= arready_next;
			s_axi_rvalid <= rvalid_next;
			s_axi_rdata <= rdata_next;
			s_axi_rresp <= rresp_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// Port state registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl_reg <= pio_pkg::CTRL_RESET;
			out_reg <= pio_pkg::DATA_RESET;
			in_reg <= pio_pkg::DATA_RESET;
			shadow_reg <= pio_pkg::DATA_RESET;
			shadow_vld_reg <= 1'b0;
			viol_reg <= 1'b0;
			ids_d_reg <= 1'b1;
			ods_d_reg <= 1'b1;
			irq_in_reg <= 1'b0;
			irq_out_reg <= 1'b0;
			interrupt_acknowledge_reg <= 1'b0;
			eng_reg <= pio_pkg::ENG_IDLE;
			cnt_reg <= 4'h0;
			eng_wr_reg <= 1'b0;
			sel_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			out_reg <= out_next;
			in_reg <= in_next;
			shadow_reg <= shadow_next;
			shadow_vld_reg <= shadow_vld_next;
			viol_reg <= viol_next;
			ids_d_reg <= ids_d_next;
			ods_d_reg <= ods_d_next;
			irq_in_reg <= irq_in_next;
			irq_out_reg <= irq_out_next;
			interrupt_acknowledge_reg <= interrupt_acknowledge_next;
			eng_reg <= eng_next;
			cnt_reg <= cnt_next;
			eng_wr_reg <= eng_wr_next;
			sel_reg <= sel_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// Pin registers; every pin output comes from a flip-flop
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ids_out_reg <= 1'b1;
			ods_out_reg <= 1'b1;
			ids_oe_reg <= 1'b0;
			ods_oe_reg <= 1'b0;
			pdb_out_reg <= pio_pkg::DATA_RESET;
			pdb_oe_reg <= 16'h0000;
		end else begin
			ids_out_reg <= ids_out_next;
			ods_out_reg <= ods_out_next;
			ids_oe_reg <= ids_oe_next;
			ods_oe_reg <= ods_oe_next;
			pdb_out_reg <= pdb_out_next;
			pdb_oe_reg <= pdb_oe_next;
		end
	end

	// Outputs straight from the registers above
	assign input_data_strobe_n_out = ids_out_reg;
	assign input_data_strobe_n_oe = ids_oe_reg;
	assign output_data_strobe_n_out = ods_out_reg;
	assign output_data_strobe_n_oe = ods_oe_reg;
	assign parallel_data_bus_out = pdb_out_reg;
	assign parallel_data_bus_oe = pdb_oe_reg;
	assign port_select = sel_reg;
	assign irq_input_req = irq_in_reg;
	assign irq_output_req = irq_out_reg;
	assign interrupt_acknowledge = interrupt_acknowledge_reg;
endmodule
`default_nettype wire

/* File: inc/pio_pkg.sv */
// Behaviour
// - Width field selects one to four T units
// - Minimum width allows back-to-back transactions
// - Wider strobes need idle gap between transactions
// - Service routines keep the same transaction spacing
// - Bit 12 clear: output strobe is input
// - Bit 11 clear: input strobe is input
// - Passive strobe raises interrupt only when unmasked
// - Bit 10 makes upper byte input only
// - S/C mode: lower byte full, upper input
// - Passive write requests interrupt on strobe rise
// - Passive read requests interrupt on strobe rise
// - Acknowledge rises on accept, falls on return
// - Acknowledge falling edge paces external writer
// - Input register shadowed across interrupt when active
// - Active read asserts input strobe and sets select to its port
// - Active write drives data through strobe plus hold
// - Passive read drives output register until negation
// - Select high for port one, low zero
// - Input data sampled on input strobe rise
package pio_pkg;
	// Clock and strobe unit; T is twice the clock-high time
	localparam int CLK_MHZ = 100;
	localparam int CLK_HIGH_NS = 5;
	localparam int T_UNIT_NS = 2 * CLK_HIGH_NS;
	localparam int T_UNIT_CYC_I = (T_UNIT_NS * CLK_MHZ + 999) / 1000;
	localparam logic [3:0] T_UNIT_CYCLES = 4'(T_UNIT_CYC_I);
	// Delay from pin to synchroniser output, used to line up active-read sampling
	localparam int SYNC_STAGES = 2;
	localparam int PIN_W = 18;
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_DATA0 = 8'h04;
	localparam logic [7:0] ADDR_DATA1 = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_OUTREG = 8'h10;
	// Control field positions
	localparam int CTRL_WIDTH_LSB = 13;
	localparam int CTRL_OUT_ACT = 12;
	localparam int CTRL_IN_ACT = 11;
	localparam int CTRL_SC = 10;
	localparam int CTRL_MASK_IN = 0;
	localparam int CTRL_MASK_OUT = 1;
	localparam logic [15:0] CTRL_WMASK = 16'h7c03;
	// Status field positions
	localparam int ST_BUSY = 0;
	localparam int ST_IRQ_IN = 1;
	localparam int ST_IRQ_OUT = 2;
	localparam int ST_INTERRUPT_ACKNOWLEDGE = 3;
	localparam int ST_VIOL = 4;
	localparam int ST_SHADOW = 5;
	// Reset values
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] DATA_RESET = 16'h0000;
	localparam logic [PIN_W-1:0] PIN_IDLE = 18'h30000;
	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// Strobe engine states
	typedef enum logic [1:0] {
		ENG_IDLE = 2'b00,
		ENG_STROBE = 2'b01,
		ENG_GAP = 2'b10
	} pio_eng_t;
endpackage

/* File: verilog/pio_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for the pin inputs
module pio_sync #(
	parameter int W = 18,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] stage1_reg; // Only the second stage reads this

	////////////////////////////////////////////////////////////////
	// Both stages reset to the idle pin levels
	always_ff @(posedge core_clk) begin
		if (rst) begin
			stage1_reg <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			stage1_reg <= async_in;
			sync_out <= stage1_reg;
		end
	end
endmodule
`default_nettype wire

/* File: tb/pio_port_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// Pin checks on strobes and bus enables
module pio_mon (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [15:0] parallel_data_bus_oe,
	input wire logic input_data_strobe_n_out,
	input wire logic input_data_strobe_n_oe,
	input wire logic output_data_strobe_n_in,
	input wire logic output_data_strobe_n_out,
	input wire logic output_data_strobe_n_oe
);
	wire logic wr_lo = output_data_strobe_n_oe && !output_data_strobe_n_out; // Write strobe
	wire logic rd_lo = input_data_strobe_n_oe && !input_data_strobe_n_out; // Read strobe
	wire logic hr_lo = !output_data_strobe_n_oe && !output_data_strobe_n_in; // Host read
	wire logic lo_on = &parallel_data_bus_oe[7:0]; // Lower byte driven
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Host read held past the synchroniser
	sequence s_host_rd;
		hr_lo [*4];
	endsequence
	AST_OW: assert property (wr_lo [*4] |=> !wr_lo) else $error("wide");
	AST_IW: assert property (rd_lo [*4] |=> !rd_lo) else $error("wide");
	AST_OD: assert property (wr_lo [*2] |-> lo_on) else $error("no data");
	AST_OH: assert property ($fell(wr_lo) |-> lo_on) else $error("no hold");
	AST_IB: assert property (rd_lo |-> !lo_on) else $error("clash");
	AST_HR: assert property (s_host_rd |-> lo_on) else $error("no data");
	AST_HH: assert property (s_host_rd ##1 !hr_lo |-> lo_on) else $error("no hold");
	AST_ONE: assert property (!(wr_lo && rd_lo)) else $error("overlap");
endmodule
bind pio_port pio_mon mon (.*);
`default_nettype wire

/* File: tb/pio_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Far-side host; a released bus shows the inverse of its last value
module pio_host (
	input wire logic core_clk,
	input wire logic [15:0] parallel_data_bus_out,
	input wire logic [15:0] parallel_data_bus_oe,
	output logic [15:0] parallel_data_bus_in,
	output logic input_data_strobe_n_in = 1'h1,
	output logic output_data_strobe_n_in = 1'h1
);
	logic [15:0] dat = 16'h0;
	logic drv = 1'h0;
	assign parallel_data_bus_in = parallel_data_bus_oe & parallel_data_bus_out |
		~parallel_data_bus_oe & (drv ? dat : ~dat);
	// Write drives data across the whole strobe; read samples before release
	task automatic hx(input logic w, inout logic [15:0] v);
		dat <= v;
		drv <= w;
		{input_data_strobe_n_in, output_data_strobe_n_in} <= {!w, w};
		repeat (6) @(posedge core_clk);
		v = parallel_data_bus_in;
		{input_data_strobe_n_in, output_data_strobe_n_in} <= 2'h3;
		@(posedge core_clk);
		drv <= 1'h0;
	endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic core_clk = 1'h0, rst = 1'h1, int_accept = 1'h0, int_done = 1'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, port_select, irq_input_req, irq_output_req;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] parallel_data_bus_in, parallel_data_bus_out, parallel_data_bus_oe;
	logic input_data_strobe_n_in, input_data_strobe_n_out, input_data_strobe_n_oe;
	logic output_data_strobe_n_in, output_data_strobe_n_out, output_data_strobe_n_oe;
	logic interrupt_acknowledge;
	int err_count = 0, cmp_count = 0;
	logic [17:0] exp_q[$]; // Response code and low word per read
	pio_port dut (.*);
	pio_host host (.*);
	initial forever #5 core_clk = ~core_clk;
	task automatic check(input logic [17:0] got, input logic [17:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("errors %0d checks %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// One bus access; valids drop once taken, ready holds until answered
	task automatic ax(input logic r, input logic [7:0] a, input logic [17:0] d);
		logic ok = 1'h0;
		if (r) exp_q.push_back(d);
		@(posedge core_clk);
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, 16'h0, d[15:0]};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{!r}};
		{s_axi_arvalid, s_axi_rready} <= {2{r}};
		for (int n = 0; n < 99 && !ok; n++) begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			ok = r ? s_axi_rvalid : s_axi_bvalid;
		end
		{s_axi_bready, s_axi_rready} <= 2'h0;
		if (!ok) begin
			check(18'h1, 18'h0);
			report_and_stop;
		end
	endtask
	// Oldest note is matched to each read answer
	always @(posedge core_clk)
		if (s_axi_rvalid && s_axi_rready)
			check({s_axi_rresp, s_axi_rdata[15:0]}, exp_q.pop_front());
	initial begin
		logic [15:0] v, g;
		v = 16'($urandom(32'h5019));
		repeat (20) @(posedge core_clk);
		rst <= 1'h0;
		ax(1'h0, pio_pkg::ADDR_CTRL, 18'h3); // Both strobes passive
		host.hx(1'h1, v);
		ax(1'h1, pio_pkg::ADDR_DATA0, {pio_pkg::RESP_OKAY, v});
		check({17'h0, irq_input_req}, 18'h1);
		int_accept <= 1'h1;
		@(posedge core_clk);
		int_accept <= 1'h0;
		repeat (2) @(posedge core_clk);
		check({16'h0, irq_input_req, interrupt_acknowledge}, 18'h1);
		int_done <= 1'h1;
		@(posedge core_clk);
		int_done <= 1'h0;
		repeat (2) @(posedge core_clk);
		check({17'h0, interrupt_acknowledge}, 18'h0);
		g = ~v;
		ax(1'h0, pio_pkg::ADDR_DATA0, {2'h0, g});
		host.hx(1'h0, v);
		check({2'h0, v}, {2'h0, g});
		repeat (3) @(posedge core_clk);
		check({17'h0, irq_output_req}, 18'h1);
		for (int w = 0; w < 4; w++) begin
			v = 16'(w << 13) | 16'h1c00; // Active strobes, status/control mode
			ax(1'h0, pio_pkg::ADDR_CTRL, {2'h0, v});
			ax(1'h1, pio_pkg::ADDR_CTRL, {pio_pkg::RESP_OKAY, v});
			ax(1'h1, pio_pkg::ADDR_DATA0, {pio_pkg::RESP_OKAY, (w != 0) ? g : ~g});
			repeat (8) @(posedge core_clk);
			check({17'h0, port_select}, 18'h0);
			ax(1'h0, pio_pkg::ADDR_DATA1, 18'($urandom));
			check({17'h0, port_select}, 18'h1);
		end
		ax(1'h1, 8'h40, {pio_pkg::RESP_SLVERR, 16'h0}); // Unmapped word
		report_and_stop;
	end
endmodule
`default_nettype wire
